// *** logic/tx_serdes_irq_regs.sv ***
// Function
// R01 - read-only eight-bit channel B mask, one marks matching data bit valid
// R02 - host may skip mask read when whole byte reported valid
// R03 - host writes zeros to enable bits 7:4
// R04 - enable bit one lets its status raise interrupt, zero suppresses
// R05 - underflow sets when transmitter wants data but none held, after first bit
// R06 - overflow sets when host writes data before previous byte moved to shifter
// R07 - done sets when byte finished and nothing queued, after first bit
// R08 - empty sets when data register moves into transmitter
// R09 - host write to transmit data register clears empty
// R10 - status read clears underflow, overflow and done
// R11 - status latches regardless of enable bits
// R12 - transmit status reads zero outside transmit mode
// R13 - status register read-only, upper four bits reserved
// R14 - interrupt asserted while any enabled status bit is set
module tx_serdes_irq_regs
   import tx_serdes_irq_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       tx_enable,
   input  wire logic       tx_load_shifter,
   input  wire logic       tx_sample_req,
   input  wire logic       tx_byte_finished,
   input  wire logic       rx_b_mask_load,
   input  wire logic [7:0] rx_b_mask_in,
   output logic            tx_data_full,
   output logic            irq
);
   import tx_serdes_irq_pkg::*;

   logic [7:0]            rx_b_mask_ff;
   logic [STAT_WIDTH-1:0] irq_enable_ff;
   logic [STAT_WIDTH-1:0] status_ff;
   logic [STAT_WIDTH-1:0] seen_status;
   logic [STAT_WIDTH-1:0] set_pulse;
   logic [STAT_WIDTH-1:0] clr_pulse;
   logic                  data_full_ff;
   logic                  bit_sent_ff;
   logic [7:0]            nxt_rdata;
   logic                  data_wr;
   logic                  stat_rd;

   assign data_wr = reg_wr && (reg_addr == TX_DATA_OFS);
   assign stat_rd = reg_rd && (reg_addr == TX_IRQ_STATUS_OFS);

   // channel B mask, loaded by correlator
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_b_mask_ff <= RX_CHAN_B_VALID_RST;
      end else if (rx_b_mask_load) begin
         rx_b_mask_ff <= rx_b_mask_in; // R01
      end
   end

   // host ignores bits 7:4 per contract; stored width is four
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_enable_ff <= TX_IRQ_ENABLE_RST;
      end else if (reg_wr && (reg_addr == TX_IRQ_ENABLE_OFS)) begin
         irq_enable_ff <= reg_wdata[STAT_WIDTH-1:0]; // R03
      end
   end

   // holding-register occupancy
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         data_full_ff <= 1'b0;
      end else if (data_wr) begin
         data_full_ff <= 1'b1;
      end else if (tx_load_shifter) begin
         data_full_ff <= 1'b0;
      end
   end

   // at least one bit sent since transmit mode entered
   always_ff @(posedge sys_clk) begin
      if (reset || !tx_enable) begin
         bit_sent_ff <= 1'b0;
      end else if (tx_load_shifter) begin
         bit_sent_ff <= 1'b1;
      end
   end

   always_comb begin
      set_pulse = '0;
      set_pulse[STAT_UNDERFLOW_BIT] = tx_enable && tx_sample_req && !data_full_ff && bit_sent_ff; // R05
      set_pulse[STAT_OVERFLOW_BIT]  = tx_enable && data_wr && data_full_ff && !tx_load_shifter; // R06
      set_pulse[STAT_DONE_BIT]      = tx_enable && tx_byte_finished && !data_full_ff && bit_sent_ff; // R07
      set_pulse[STAT_EMPTY_BIT]     = tx_enable && tx_load_shifter; // R08
   end

   always_comb begin
      clr_pulse = '0;
      clr_pulse[STAT_EMPTY_BIT]     = data_wr || !tx_enable; // R09
      clr_pulse[STAT_DONE_BIT]      = stat_rd || !tx_enable; // R10
      clr_pulse[STAT_OVERFLOW_BIT]  = stat_rd || !tx_enable; // R10
      clr_pulse[STAT_UNDERFLOW_BIT] = stat_rd || !tx_enable; // R10
   end

   // latched independent of enables
   tx_event_latch u_latch ( // R11
      .sys_clk   (sys_clk),
      .reset     (reset),
      .set_pulse (set_pulse),
      .clr_pulse (clr_pulse),
      .flags_ff  (status_ff)
   );

   assign seen_status = tx_enable ? status_ff : '0; // R12

   always_comb begin
      nxt_rdata = 8'h00;
      unique case (reg_addr)
         RX_CHAN_B_VALID_OFS: nxt_rdata = rx_b_mask_ff; // R01
         TX_IRQ_ENABLE_OFS:   nxt_rdata = {4'h0, irq_enable_ff};
         TX_IRQ_STATUS_OFS:   nxt_rdata = {4'h0, seen_status}; // R13
         default:             nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= nxt_rdata;
      end
   end

   assign tx_data_full = data_full_ff;
   assign irq = |(seen_status & irq_enable_ff); // R04 R14
endmodule : tx_serdes_irq_regs

// *** logic/tx_serdes_irq_pkg.sv ***
package tx_serdes_irq_pkg;
   localparam logic [7:0] RX_CHAN_B_VALID_OFS = 8'h0c;
   localparam logic [7:0] TX_IRQ_ENABLE_OFS   = 8'h0d;
   localparam logic [7:0] TX_IRQ_STATUS_OFS   = 8'h0e;
   localparam logic [7:0] TX_DATA_OFS         = 8'h0f;
   localparam logic [7:0] RX_CHAN_B_VALID_RST = 8'h00;
   localparam logic [3:0] TX_IRQ_ENABLE_RST   = 4'h0;
   localparam logic [3:0] TX_IRQ_STATUS_RST   = 4'h0;
   localparam int         STAT_EMPTY_BIT      = 0;
   localparam int         STAT_DONE_BIT       = 1;
   localparam int         STAT_OVERFLOW_BIT   = 2;
   localparam int         STAT_UNDERFLOW_BIT  = 3;
   localparam int         STAT_WIDTH          = 4;
endpackage : tx_serdes_irq_pkg

// *** logic/tx_event_latch.sv ***
// sticky event bits; set wins over clear
module tx_event_latch (
   input  wire logic                                    sys_clk,
   input  wire logic                                    reset,
   input  wire logic [tx_serdes_irq_pkg::STAT_WIDTH-1:0] set_pulse,
   input  wire logic [tx_serdes_irq_pkg::STAT_WIDTH-1:0] clr_pulse,
   output logic      [tx_serdes_irq_pkg::STAT_WIDTH-1:0] flags_ff
);
   import tx_serdes_irq_pkg::*;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flags_ff <= TX_IRQ_STATUS_RST;
      end else begin
         flags_ff <= set_pulse | (flags_ff & ~clr_pulse);
      end
   end
endmodule : tx_event_latch

// *** tb/tx_serdes_irq_checker.sv ***
module tx_serdes_irq_checker
   import tx_serdes_irq_pkg::*;
(
   input wire logic       sys_clk, reset, reg_wr, reg_rd, tx_enable, tx_load_shifter, tx_sample_req,
   input wire logic       tx_byte_finished, rx_b_mask_load, tx_data_full, irq,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_b_mask_in
);
   wire rd_st  = reg_rd && reg_addr == TX_IRQ_STATUS_OFS;
   wire wr_dat = reg_wr && reg_addr == TX_DATA_OFS;
   wire calm   = !tx_sample_req && !tx_byte_finished && !wr_dat;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_quiet; reg_wr && reg_addr == TX_IRQ_ENABLE_OFS && reg_wdata[3:0] == 4'h0 |=> !irq; endproperty
   a_quiet: assert property (p_quiet) else $error("irq while disabled");
   property p_mask; rx_b_mask_load ##1 !rx_b_mask_load ##1 reg_rd && reg_addr == RX_CHAN_B_VALID_OFS
      |=> reg_rdata == $past(rx_b_mask_in, 3); endproperty
   a_mask: assert property (p_mask) else $error("mask read");
   property p_top; rd_st |=> reg_rdata[7:4] == 4'h0; endproperty
   a_top: assert property (p_top) else $error("reserved bits");
   property p_idle; !tx_enable ##1 !tx_enable |-> !irq; endproperty
   a_idle: assert property (p_idle) else $error("irq when idle");
   property p_idle_rd; !tx_enable ##1 !tx_enable && rd_st |=> reg_rdata == 8'h00; endproperty
   a_idle_rd: assert property (p_idle_rd) else $error("status when idle");
   property p_fill; wr_dat && tx_enable && !tx_load_shifter |=> tx_data_full; endproperty
   a_fill: assert property (p_fill) else $error("full not set");
   property p_take; tx_load_shifter && tx_enable && !wr_dat |=> !tx_data_full; endproperty
   a_take: assert property (p_take) else $error("full not cleared");
   property p_clr; rd_st && calm ##1 calm ##1 rd_st |=> reg_rdata[3:1] == 3'h0; endproperty
   a_clr: assert property (p_clr) else $error("status not cleared");
   c_irq: cover property (irq);
   c_ovf: cover property (wr_dat && tx_data_full);
   c_rd: cover property (rd_st && tx_enable);
endmodule : tx_serdes_irq_checker
bind tx_serdes_irq_regs tx_serdes_irq_checker u_chk (.*);

// *** tb/host_model.sv ***
module host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr, reg_wdata,
   output logic            reg_wr, reg_rd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
   task xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge sys_clk) #1;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
      @(posedge sys_clk) #1;
      q = reg_rdata;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00}; // released address and data lines flip; write and read strobes drop to zero
   endtask : xfer
endmodule : host_model

// *** tb/test_tx_serdes_irq_regs.sv ***
module test_tx_serdes_irq_regs;
   import tx_serdes_irq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       sys_clk = 0, reset = 1, tx_enable = 0, ld = 0, smp = 0, fin = 0, mld = 0, wr, rr, full, irq;
   logic [7:0] a, wd, rd, q, mask = 0, adr [4] = '{8'h0c, 8'h0d, 8'h0e, 8'h20};
   int         failures = 0, total_checks = 0, st = 0, en = 0, fl = 0, sent = 0, k;
   tx_serdes_irq_regs u_tx_serdes_irq_regs (.sys_clk, .reset, .reg_addr(a), .reg_wr(wr), .reg_rd(rr),
      .reg_wdata(wd), .reg_rdata(rd), .tx_enable, .tx_load_shifter(ld), .tx_sample_req(smp),
      .tx_byte_finished(fin), .rx_b_mask_load(mld), .rx_b_mask_in(mask), .tx_data_full(full), .irq);
   host_model u_host_model (.sys_clk, .reg_rdata(rd), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rr));
   initial forever #5 sys_clk = ~sys_clk;
   task chk(input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: %h vs %h", $time, s, e);
      end
   endtask : chk
   task rdc(input logic [7:0] ad, e);
      u_host_model.xfer(0, ad, 8'h00, q);
      chk(q, e);
   endtask : rdc
   task ev(input logic l, s, f);
      @(posedge sys_clk) #1;
      {ld, smp, fin} = {l, s, f};
      if (s && fl == 0 && sent == 1) st |= 8;
      if (f && fl == 0 && sent == 1) st |= 2;
      if (l) begin
         st |= 1;
         fl = 0;
         sent = 1;
      end
      @(posedge sys_clk) #1;
      {ld, smp, fin} = 3'b000;
   endtask : ev
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   initial begin
      #200000;
      failures++;
      end_sim();
   end
   initial begin
      void'($urandom(32'habfd991c));
      repeat (12) @(posedge sys_clk);
      #1 reset = 0;
      foreach (adr[i]) rdc(adr[i], 8'h00);
      $display("test reset done");
      mask = 8'($urandom);
      mld = 1;
      @(posedge sys_clk) #1;
      mld = 0;
      rdc(RX_CHAN_B_VALID_OFS, mask);
      u_host_model.xfer(1, RX_CHAN_B_VALID_OFS, ~mask, q);
      rdc(RX_CHAN_B_VALID_OFS, mask);
      tx_enable = 1;
      u_host_model.xfer(1, TX_IRQ_STATUS_OFS, 8'hff, q);
      rdc(TX_IRQ_STATUS_OFS, 8'h00);
      u_host_model.xfer(1, TX_IRQ_ENABLE_OFS, 8'h0f, q);
      en = 15;
      rdc(TX_IRQ_ENABLE_OFS, 8'h0f);
      $display("test registers done");
      repeat (300) begin
         k = $urandom_range(5);
         if (k < 3) ev(k == 0, k == 1, k == 2);
         else if (k == 3) begin
            if (fl == 1) st |= 4;
            st &= 14;
            fl = 1;
            u_host_model.xfer(1, TX_DATA_OFS, 8'($urandom), q);
         end else if (k == 4) begin
            rdc(TX_IRQ_STATUS_OFS, 8'(st));
            st &= 1;
         end else begin
            en = $urandom_range(15);
            u_host_model.xfer(1, TX_IRQ_ENABLE_OFS, 8'(en), q);
         end
         chk(irq, |(st & en));
         chk(full, fl);
      end
      $display("test events done");
      u_host_model.xfer(1, TX_IRQ_ENABLE_OFS, 8'h0f, q);
      tx_enable = 0;
      repeat (2) @(posedge sys_clk);
      #1 chk(irq, 8'h00);
      rdc(TX_IRQ_STATUS_OFS, 8'h00);
      u_host_model.xfer(1, TX_IRQ_ENABLE_OFS, 8'h00, q);
      chk(irq, 8'h00);
      $display("test idle done");
      end_sim();
   end
endmodule : test_tx_serdes_irq_regs
